// file: include/rpmc_pkg.sv
// constants and types shared by the reset and power mode control block
package rpmc_pkg;

  // register byte offsets on the avalon slave
  localparam logic [4:0] ADDR_CFG     = 5'h00;
  localparam logic [4:0] ADDR_CAUSE   = 5'h04;
  localparam logic [4:0] ADDR_BOOTVEC = 5'h08;
  localparam logic [4:0] ADDR_PWR     = 5'h0c;
  localparam logic [4:0] ADDR_STATUS  = 5'h10;

  // configuration register fields
  localparam int CFG_PIN_ENABLE_A = 0;
  localparam int CFG_PIN_ENABLE_B = 1;
  localparam int CFG_BOD_EN       = 2;
  localparam int CFG_BOD_IRQ      = 3;
  localparam int CFG_BOOT_STAT    = 4;
  localparam int CFG_CMP_PD       = 5;
  localparam int CFG_RC_SEL       = 6;
  localparam int CFG_RTC_EN       = 7;
  localparam logic [7:0] CFG_RESET     = 8'h05;
  localparam logic [7:0] BOOTVEC_RESET = 8'h00;

  // reset cause register fields
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BOD = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_SW  = 4;
  localparam int CAUSE_BRK = 5;
  localparam logic [5:0] CAUSE_POR_VALUE = 6'h06;

  // power register fields
  localparam int PWR_SWRST = 4;

  // shared reset pin modes {enable_b, enable_a}
  localparam logic [1:0] PIN_GPIO    = 2'h0;
  localparam logic [1:0] PIN_RST_IN  = 2'h1;
  localparam logic [1:0] PIN_RST_OD  = 2'h2;
  localparam logic [1:0] PIN_RST_OUT = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_PWRUP_NS    = 1000;
  localparam int T_RST_HOLD_NS = 100;
  localparam int PWRUP_CYC_I   =
    (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HOLD_I    =
    (T_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] PWRUP_LAST      = 6'(PWRUP_CYC_I - 1);
  localparam logic [2:0] RST_HOLD_CYCLES = 3'(RST_HOLD_I);
  localparam logic [3:0] BREAK_LOW_BITS  = 4'hb;

  typedef enum logic [1:0] {PM_NORMAL, PM_IDLE, PM_PD, PM_TPD} rpmc_pmode_t;

endpackage : rpmc_pkg

// file: rtl/rpmc_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module rpmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rpmc_sync_t;

  rpmc_sync_t s;
  rpmc_sync_t next_s;

  always_comb
  begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign q = s.s2;
endmodule : rpmc_sync

// file: rtl/rpmc_brk.sv
// break detector: pulses once when enough received samples in a row are low
`timescale 1ns/1ns
module rpmc_brk (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  // receive samples
  input  wire logic sample,
  input  wire logic rx_bit,
  // break event
  output      logic brk
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       brk;
  } rpmc_brk_t;

  rpmc_brk_t s;
  rpmc_brk_t next_s;

  always_comb
  begin
    next_s     = s;
    next_s.brk = 1'b0;
    if (sample)
    begin
      if (rx_bit)
        next_s.cnt = 4'h0;
      else if (s.cnt != rpmc_pkg::BREAK_LOW_BITS)
      begin
        next_s.cnt = s.cnt + 4'h1;
        next_s.brk = (s.cnt == rpmc_pkg::BREAK_LOW_BITS - 4'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign brk = s.brk;

  property p_brk_fire;
    @(posedge clk) disable iff (!resetn)
    (ce && sample && !rx_bit && s.cnt == 4'ha) |=> brk;
  endproperty
  a_brk_fire: assert property (p_brk_fire)
    else $error("break not flagged after eleven low samples");

  property p_brk_cause;
    @(posedge clk) disable iff (!resetn)
    brk |-> s.cnt == 4'hb && $past(sample) && !$past(rx_bit);
  endproperty
  a_brk_cause: assert property (p_brk_cause)
    else $error("break flagged without eleven low samples");
endmodule : rpmc_brk

// file: rtl/rpmc_top.sv
// reset sources, cause flags, reset pin, boot vector and power modes
`timescale 1ns/1ns
// What this block does
// - pin mode from two config bits: gpio, input, open-drain, output
// - during power-up the pin is always a reset input
// - only power-up overrides the pin mode; other resets keep it
// - reset from pin, power-on, brownout, watchdog, software, uart break
// - one readable cause flag per reset source
// - writing zero clears a cause flag; several may be set
// - power-on reset sets power-on and brownout flags, clears others
// - other resets keep all uncleared cause flags
// - power-on flag set at power-up and held until software clears it
// - boot address is boot vector high byte with zero low byte
// - boot after break reset, boot status set, or forced isp at power-on
// - brownout resets by default, or raises an interrupt when configured
// - brownout disabled gives neither reset nor interrupt
// - brownout condition follows the supply detector while enabled
// - idle keeps peripherals running; interrupt or reset ends it
// - power-down stops the oscillator; exit on reset or wake interrupt
// - in power-down brownout, watchdog, comparators and rtc keep running
// - rc oscillator off in power-down unless system clock and rtc enabled
// - total power-down also stops brownout detect and comparators
// - break source fires after eleven consecutive low samples
// - rtc and its registers are reset only by power-on
module rpmc_top (
  // clock, power-on reset and clock enable
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  // avalon-mm slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output      logic [31:0] AVS_READDATA,
  output      logic        AVS_WAITREQUEST,
  // shared reset pin
  input  wire logic        PIN_I,
  output      logic        PIN_O,
  output      logic        PIN_OE,
  output      logic        PIN_PULLUP,
  // reset and wake sources
  input  wire logic        BOD_LOW,
  input  wire logic        ISP_FORCE,
  input  wire logic        WDT_RESET,
  input  wire logic        UART_RX_SAMPLE,
  input  wire logic        UART_RX_BIT,
  input  wire logic        WAKE_IRQ,
  input  wire logic        PD_WAKE_IRQ,
  // reset and boot results
  output      logic        CORE_RESET_N,
  output      logic [15:0] FETCH_ADDR,
  output      logic        BROWNOUT_IRQ,
  output      logic        RTC_RESET_N,
  // power domain controls
  output      logic        CPU_RUN,
  output      logic        PERIPH_RUN,
  output      logic        OSC_RUN,
  output      logic        RC_OSC_RUN,
  output      logic        BOD_RUN,
  output      logic        CMP_RUN,
  output      logic        RTC_RUN
);
  typedef struct packed {
    logic                      waitreq;
    logic [31:0]               rdata;
    logic [7:0]                cfg;
    logic [7:0]                boot_vec;
    logic [5:0]                flags;
    rpmc_pkg::rpmc_pmode_t     pmode;
    logic [5:0]                pwrup_cnt;
    logic                      pwrup_done;
    logic                      isp_seen;
    logic [2:0]                hold_cnt;
    logic                      core_rst;
    logic                      core_rst_n;
    logic                      break_cause;
    logic [15:0]               fetch_addr;
    logic                      pin_o;
    logic                      pin_oe;
    logic                      pin_pu;
    logic [1:0]                od_mask;
    logic                      bod_irq;
    logic                      cpu_run;
    logic                      periph_run;
    logic                      osc_run;
    logic                      rc_run;
    logic                      bod_run;
    logic                      cmp_run;
    logic                      rtc_run;
    logic                      rtc_rst_n;
  } rpmc_state_t;

  rpmc_state_t s;
  rpmc_state_t next_s;

  logic [2:0] sync_q;
  logic       pin_s;
  logic       bod_s;
  logic       isp_s;
  logic       brk;
  logic [1:0] pin_mode;
  logic       pin_rst;
  logic       bod_cond;
  logic       bod_rst;
  logic       take;
  logic       wr_take;
  logic       sw_rst;
  logic [5:0] set_ev;
  logic       boot_sel;
  logic       running;
  // pin, brownout detector and isp strap are asynchronous
  rpmc_sync #(
    .W (3)
  ) u_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .ce     (CE),
    .d      ({ISP_FORCE, BOD_LOW, PIN_I}),
    .q      (sync_q)
  );

  rpmc_brk u_brk (
    .clk    (CLK),
    .resetn (RESETN),
    .ce     (CE),
    .sample (UART_RX_SAMPLE),
    .rx_bit (UART_RX_BIT),
    .brk    (brk)
  );
  assign pin_s = sync_q[0];
  assign bod_s = sync_q[1];
  assign isp_s = sync_q[2];
  always_comb
  begin
    next_s = s;
    // pin acts as reset input until power-up completes
    pin_mode = s.pwrup_done
      ? {s.cfg[rpmc_pkg::CFG_PIN_ENABLE_B], s.cfg[rpmc_pkg::CFG_PIN_ENABLE_A]}
      : rpmc_pkg::PIN_RST_IN;
    pin_rst = !pin_s && (pin_mode == rpmc_pkg::PIN_RST_IN ||
      (pin_mode == rpmc_pkg::PIN_RST_OD && s.od_mask == 2'h0));
    bod_cond = s.cfg[rpmc_pkg::CFG_BOD_EN] && bod_s &&
      s.pmode != rpmc_pkg::PM_TPD;
    bod_rst = bod_cond && !s.cfg[rpmc_pkg::CFG_BOD_IRQ];
    // avalon slave: one wait cycle, then answer
    take    = (AVS_READ || AVS_WRITE) && !s.waitreq;
    wr_take = AVS_WRITE && take && s.pwrup_done;
    sw_rst  = wr_take && AVS_ADDRESS == rpmc_pkg::ADDR_PWR &&
      AVS_WRITEDATA[rpmc_pkg::PWR_SWRST];
    next_s.waitreq = !((AVS_READ || AVS_WRITE) && s.waitreq);
    if (AVS_READ && s.waitreq)
    begin
      unique case (AVS_ADDRESS)
        rpmc_pkg::ADDR_CFG:     next_s.rdata = {24'h000000, s.cfg};
        rpmc_pkg::ADDR_CAUSE:   next_s.rdata = {26'h0000000, s.flags};
        rpmc_pkg::ADDR_BOOTVEC: next_s.rdata = {24'h000000, s.boot_vec};
        rpmc_pkg::ADDR_PWR:     next_s.rdata = {30'h00000000, s.pmode};
        rpmc_pkg::ADDR_STATUS:
          next_s.rdata = {14'h0000, pin_s, bod_cond, s.fetch_addr};
        default:                next_s.rdata = 32'h00000000;
      endcase
    end
    if (wr_take)
    begin
      unique case (AVS_ADDRESS)
        rpmc_pkg::ADDR_CFG:     next_s.cfg = AVS_WRITEDATA[7:0];
        rpmc_pkg::ADDR_BOOTVEC: next_s.boot_vec = AVS_WRITEDATA[7:0];
        rpmc_pkg::ADDR_CAUSE:
          next_s.flags = s.flags & AVS_WRITEDATA[5:0];
        rpmc_pkg::ADDR_PWR:
          next_s.pmode = rpmc_pkg::rpmc_pmode_t'(AVS_WRITEDATA[1:0]);
        default:                next_s.cfg = s.cfg;
      endcase
    end

    // reset sources; a set in the clearing cycle wins
    set_ev = '0;
    set_ev[rpmc_pkg::CAUSE_EXT] = pin_rst && s.pwrup_done;
    set_ev[rpmc_pkg::CAUSE_BOD] = bod_rst;
    set_ev[rpmc_pkg::CAUSE_WDT] = WDT_RESET;
    set_ev[rpmc_pkg::CAUSE_SW]  = sw_rst;
    set_ev[rpmc_pkg::CAUSE_BRK] = brk;
    next_s.flags = next_s.flags | set_ev;
    if (brk)
      next_s.break_cause = 1'b1;

    // power-up count restarts from zero while the pin is held low
    if (!s.pwrup_done)
    begin
      if (!pin_s)
        next_s.pwrup_cnt = 6'h00;
      else if (s.pwrup_cnt == rpmc_pkg::PWRUP_LAST)
      begin
        next_s.pwrup_done = 1'b1;
        next_s.isp_seen   = isp_s;
      end
      else
        next_s.pwrup_cnt = s.pwrup_cnt + 6'h01;
    end

    // stretch and hold internal reset while any source is active
    if (|set_ev)
      next_s.hold_cnt = rpmc_pkg::RST_HOLD_CYCLES;
    else if (s.hold_cnt != 3'h0)
      next_s.hold_cnt = s.hold_cnt - 3'h1;
    next_s.core_rst = !next_s.pwrup_done || next_s.hold_cnt != 3'h0;
    next_s.core_rst_n = !next_s.core_rst;

    // reset vector chosen at release
    boot_sel = s.break_cause || s.cfg[rpmc_pkg::CFG_BOOT_STAT] ||
      next_s.isp_seen;
    if (s.core_rst && !next_s.core_rst)
    begin
      next_s.fetch_addr  = boot_sel ? {s.boot_vec, 8'h00} : '0;
      next_s.break_cause = 1'b0;
      next_s.isp_seen    = 1'b0;
    end

    // power modes
    unique case (s.pmode)
      rpmc_pkg::PM_IDLE:
        if (WAKE_IRQ)
          next_s.pmode = rpmc_pkg::PM_NORMAL;
      rpmc_pkg::PM_PD, rpmc_pkg::PM_TPD:
        if (PD_WAKE_IRQ)
          next_s.pmode = rpmc_pkg::PM_NORMAL;
      default:
        next_s.pmode = next_s.pmode;
    endcase
    if (next_s.core_rst)
      next_s.pmode = rpmc_pkg::PM_NORMAL;

    // registered outputs
    next_s.pin_oe = (pin_mode == rpmc_pkg::PIN_RST_OUT) ||
      (pin_mode == rpmc_pkg::PIN_RST_OD && next_s.core_rst);
    next_s.pin_o  = (pin_mode == rpmc_pkg::PIN_RST_OUT) && !next_s.core_rst;
    next_s.pin_pu = (pin_mode == rpmc_pkg::PIN_RST_IN) ||
      (pin_mode == rpmc_pkg::PIN_RST_OD);
    next_s.od_mask = next_s.pin_oe ? 2'h3 : s.od_mask - {1'b0, |s.od_mask};
    next_s.bod_irq = bod_cond && s.cfg[rpmc_pkg::CFG_BOD_IRQ];
    running = next_s.pmode == rpmc_pkg::PM_NORMAL ||
      next_s.pmode == rpmc_pkg::PM_IDLE;
    next_s.cpu_run    = next_s.pmode == rpmc_pkg::PM_NORMAL &&
      !next_s.core_rst;
    next_s.periph_run = running;
    next_s.osc_run    = running;
    next_s.rc_run     = s.cfg[rpmc_pkg::CFG_RC_SEL] &&
      (running || s.cfg[rpmc_pkg::CFG_RTC_EN]);
    next_s.bod_run    = s.cfg[rpmc_pkg::CFG_BOD_EN] &&
      next_s.pmode != rpmc_pkg::PM_TPD;
    next_s.cmp_run    = !s.cfg[rpmc_pkg::CFG_CMP_PD] &&
      next_s.pmode != rpmc_pkg::PM_TPD;
    next_s.rtc_run    = s.cfg[rpmc_pkg::CFG_RTC_EN];
    next_s.rtc_rst_n  = next_s.pwrup_done;
  end
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s          <= '0;
      s.cfg      <= rpmc_pkg::CFG_RESET;
      s.boot_vec <= rpmc_pkg::BOOTVEC_RESET;
      s.flags    <= rpmc_pkg::CAUSE_POR_VALUE;
      s.core_rst <= 1'b1;
      s.waitreq  <= 1'b1;
      s.pin_pu   <= 1'b1;
    end
    else if (CE)
      s <= next_s;
  end

  assign AVS_READDATA    = s.rdata;
  assign AVS_WAITREQUEST = s.waitreq;
  assign PIN_O           = s.pin_o;
  assign PIN_OE          = s.pin_oe;
  assign PIN_PULLUP      = s.pin_pu;
  assign CORE_RESET_N    = s.core_rst_n;
  assign FETCH_ADDR      = s.fetch_addr;
  assign BROWNOUT_IRQ    = s.bod_irq;
  assign RTC_RESET_N     = s.rtc_rst_n;
  assign CPU_RUN         = s.cpu_run;
  assign PERIPH_RUN      = s.periph_run;
  assign OSC_RUN         = s.osc_run;
  assign RC_OSC_RUN      = s.rc_run;
  assign BOD_RUN         = s.bod_run;
  assign CMP_RUN         = s.cmp_run;
  assign RTC_RUN         = s.rtc_run;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  property p_pin_out;
    (CE && s.pwrup_done && s.cfg[1:0] == 2'h3)
      |=> PIN_OE && PIN_O != s.core_rst;
  endproperty
  a_pin_out: assert property (p_pin_out)
    else $error("push-pull reset output not driven");

  property p_pwrup_pin;
    (CE && !s.pwrup_done) |=> !PIN_OE && PIN_PULLUP;
  endproperty
  a_pwrup_pin: assert property (p_pwrup_pin)
    else $error("pin not a reset input during power-up");

  property p_por_flags;
    !s.pwrup_done |-> s.flags == 6'h06;
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("cause flags wrong during power-on");

  property p_clear;
    (CE && wr_take && AVS_ADDRESS == 5'h04 && set_ev == 6'h00)
      |=> s.flags == ($past(s.flags) & $past(AVS_WRITEDATA[5:0]));
  endproperty
  a_clear: assert property (p_clear)
    else $error("cause flag write did not clear as written");

  property p_keep;
    (CE && !wr_take) |=> (s.flags & $past(s.flags)) == $past(s.flags);
  endproperty
  a_keep: assert property (p_keep)
    else $error("cause flag lost without a software write");

  property p_bod_off;
    (CE && !s.cfg[2]) [*2] |-> !BROWNOUT_IRQ;
  endproperty
  a_bod_off: assert property (p_bod_off)
    else $error("brownout interrupt while detection disabled");

  property p_hold;
    (CE && (|set_ev)) |=> s.core_rst && s.hold_cnt == 3'h5;
  endproperty
  a_hold: assert property (p_hold)
    else $error("internal reset not held for active source");

  property p_vec;
    (CE && s.core_rst && !next_s.core_rst && s.cfg[4])
      |=> FETCH_ADDR == {$past(s.boot_vec), 8'h00} && CORE_RESET_N;
  endproperty
  a_vec: assert property (p_vec)
    else $error("boot address not selected at release");

  property p_idle_wake;
    (CE && s.pmode == rpmc_pkg::PM_IDLE && WAKE_IRQ)
      |=> s.pmode == rpmc_pkg::PM_NORMAL && PERIPH_RUN;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle not ended by interrupt");

  property p_tpd;
    (CE && s.pmode == rpmc_pkg::PM_TPD && !PD_WAKE_IRQ && !wr_take &&
      !(|set_ev))
      |=> !OSC_RUN && !BOD_RUN && !CMP_RUN;
  endproperty
  a_tpd: assert property (p_tpd)
    else $error("total power-down left detectors running");

  c_sw_reset: cover property (CE && sw_rst ##[1:20] CORE_RESET_N);
  c_brk_boot: cover property (brk ##[1:20] $rose(CORE_RESET_N));
  c_pd_wake: cover property (s.pmode == rpmc_pkg::PM_PD ##1
    s.pmode == rpmc_pkg::PM_NORMAL);
  c_bod_irq: cover property ($rose(BROWNOUT_IRQ));
endmodule : rpmc_top

// file: verification/rpmc_pin_model.sv
// external reset circuit on the shared reset pin
`timescale 1ns/1ns
module rpmc_pin_model (
  // clock and power-on reset
  input  wire logic CLK,
  input  wire logic RESETN,
  // request to pull the pin low
  input  wire logic pull_low,
  // device side of the pin
  input  wire logic PIN_O,
  input  wire logic PIN_OE,
  // resolved pin level
  output      logic pin
);
  logic drv;

  // never pulls during power-on, never fights a high drive
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      drv <= 1'b0;
    else
      drv <= pull_low && !(PIN_OE && PIN_O);

  // external pull-up makes a released line high
  assign pin = !((PIN_OE && !PIN_O) || drv);
endmodule : rpmc_pin_model

// file: verification/rpmc_tb.sv
// self-checking bench for the reset and power mode control block
`timescale 1ns/1ns
module rpmc_tb;
  logic        CLK, RESETN, CE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [4:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, seed, expq[$];
  logic        PIN_I, PIN_O, PIN_OE, PIN_PULLUP, BOD_LOW, ISP_FORCE;
  logic        WDT_RESET, UART_RX_SAMPLE, UART_RX_BIT, WAKE_IRQ;
  logic        PD_WAKE_IRQ, CORE_RESET_N, BROWNOUT_IRQ, RTC_RESET_N;
  logic        CPU_RUN, PERIPH_RUN, OSC_RUN, RC_OSC_RUN, BOD_RUN;
  logic        CMP_RUN, RTC_RUN, pull_low, hit;
  logic [15:0] FETCH_ADDR;
  logic [7:0]  bv;
  int          num_errors, total_checks;

  rpmc_top i_rpmc_top (
    .CLK(CLK), .RESETN(RESETN), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_I(PIN_I), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP), .BOD_LOW(BOD_LOW),
    .ISP_FORCE(ISP_FORCE), .WDT_RESET(WDT_RESET),
    .UART_RX_SAMPLE(UART_RX_SAMPLE), .UART_RX_BIT(UART_RX_BIT),
    .WAKE_IRQ(WAKE_IRQ), .PD_WAKE_IRQ(PD_WAKE_IRQ),
    .CORE_RESET_N(CORE_RESET_N), .FETCH_ADDR(FETCH_ADDR),
    .BROWNOUT_IRQ(BROWNOUT_IRQ), .RTC_RESET_N(RTC_RESET_N),
    .CPU_RUN(CPU_RUN), .PERIPH_RUN(PERIPH_RUN), .OSC_RUN(OSC_RUN),
    .RC_OSC_RUN(RC_OSC_RUN), .BOD_RUN(BOD_RUN), .CMP_RUN(CMP_RUN),
    .RTC_RUN(RTC_RUN));

  rpmc_pin_model i_rpmc_pin_model (.CLK(CLK), .RESETN(RESETN),
    .pull_low(pull_low), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .pin(PIN_I));

  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic timeout();
    num_errors++;
    $display("wait ran out");
    end_of_test();
  endtask : timeout

  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask : cyc

  // one avalon access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !w;
    AVS_WRITE <= w;
    for (int k = 0; k < 20 && !done; k++)
    begin
      @(negedge CLK);
      done = !AVS_WAITREQUEST;
    end
    if (!done)
      timeout();
    @(posedge CLK);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : acc

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    expq.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr

  // read data compared against the oldest note
  always @(negedge CLK)
    if (AVS_READ && !AVS_WAITREQUEST)
      chk("readdata", AVS_READDATA, expq.pop_front());

  task automatic up();
    for (int k = 0; k < 200 && CORE_RESET_N !== 1'b1; k++)
      @(negedge CLK);
    if (CORE_RESET_N !== 1'b1)
      timeout();
  endtask : up

  task automatic watch(input int n, output logic r);
    r = 1'b0;
    for (int k = 0; k < n && !r; k++)
    begin
      @(negedge CLK);
      r = (CORE_RESET_N === 1'b0);
    end
    if (r)
      up();
  endtask : watch

  task automatic brk(input int n);
    @(posedge CLK);
    UART_RX_SAMPLE <= 1'b1;
    UART_RX_BIT <= 1'b0;
    repeat (n) @(posedge CLK);
    UART_RX_BIT <= 1'b1;
    @(posedge CLK);
    UART_RX_SAMPLE <= 1'b0;
  endtask : brk

  task automatic wdt(input int n);
    @(posedge CLK);
    WDT_RESET <= 1'b1;
    repeat (n) @(posedge CLK);
    WDT_RESET <= 1'b0;
  endtask : wdt

  initial
  begin
    seed = 32'd94257;
    {RESETN, AVS_READ, AVS_WRITE, BOD_LOW, ISP_FORCE, WDT_RESET} = '0;
    {UART_RX_SAMPLE, WAKE_IRQ, PD_WAKE_IRQ, pull_low} = '0;
    {AVS_ADDRESS, AVS_WRITEDATA} = '0;
    CE = 1'b1;
    UART_RX_BIT = 1'b1;
    cyc(4);
    @(posedge CLK);
    RESETN <= 1'b1;
    cyc(3);
    chk("powerup oe", PIN_OE, 0);
    chk("powerup pullup", PIN_PULLUP, 1);
    chk("powerup rtc", RTC_RESET_N, 0);
    up();
    chk("rtc reset", RTC_RESET_N, 1);
    chk("fetch", FETCH_ADDR, 0);
    rd(rpmc_pkg::ADDR_CAUSE, 32'h06);
    rd(rpmc_pkg::ADDR_CFG, 32'h05);
    rd(5'h14, 32'h0);
    wr(rpmc_pkg::ADDR_CAUSE, 32'h0);
    rd(rpmc_pkg::ADDR_CAUSE, 32'h0);
    bv = 8'(rnd()) | 8'h01;
    wr(rpmc_pkg::ADDR_BOOTVEC, {24'h0, bv});
    brk(10);
    watch(10, hit);
    chk("short break", hit, 0);
    brk(11);
    watch(10, hit);
    chk("break reset", hit, 1);
    chk("boot addr", FETCH_ADDR, {bv, 8'h00});
    chk("rtc kept", RTC_RESET_N, 1);
    rd(rpmc_pkg::ADDR_CAUSE, 32'h20);
    wdt(1 + int'(rnd() % 32'd4));
    watch(10, hit);
    chk("wdt reset", hit, 1);
    chk("wdt fetch", FETCH_ADDR, 0);
    rd(rpmc_pkg::ADDR_CAUSE, 32'h28);
    wr(rpmc_pkg::ADDR_PWR, 32'h10);
    watch(10, hit);
    chk("sw reset", hit, 1);
    rd(rpmc_pkg::ADDR_CAUSE, 32'h38);
    wr(rpmc_pkg::ADDR_CAUSE, 32'h08);
    rd(rpmc_pkg::ADDR_CAUSE, 32'h08);
    wr(rpmc_pkg::ADDR_CFG, 32'h15);
    wdt(1);
    watch(10, hit);
    chk("boot stat reset", hit, 1);
    chk("boot stat fetch", FETCH_ADDR, {bv, 8'h00});
    wr(rpmc_pkg::ADDR_CAUSE, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      wr(rpmc_pkg::ADDR_CFG, 32'(m) | 32'h04);
      cyc(2);
      chk("pin oe", PIN_OE, m == 3);
      if (m == 3)
        chk("pin drive", PIN_O, 1);
      if (m == 1 || m == 2)
        chk("pin pullup", PIN_PULLUP, 1);
      @(posedge CLK);
      pull_low <= 1'b1;
      repeat (4) @(posedge CLK);
      pull_low <= 1'b0;
      watch(12, hit);
      chk("pin reset", hit, m == 1 || m == 2);
      rd(rpmc_pkg::ADDR_CAUSE, 32'(m == 1 || m == 2));
      wr(rpmc_pkg::ADDR_CAUSE, 32'h0);
      chk("pin kept", PIN_OE, m == 3);
    end
    wr(rpmc_pkg::ADDR_CFG, 32'h0d);
    @(posedge CLK);
    BOD_LOW <= 1'b1;
    cyc(6);
    chk("bod irq", BROWNOUT_IRQ, 1);
    chk("bod no reset", CORE_RESET_N, 1);
    rd(rpmc_pkg::ADDR_STATUS, 32'h00030000);
    @(posedge CLK);
    BOD_LOW <= 1'b0;
    cyc(6);
    chk("bod irq off", BROWNOUT_IRQ, 0);
    wr(rpmc_pkg::ADDR_CFG, 32'h09);
    @(posedge CLK);
    BOD_LOW <= 1'b1;
    watch(10, hit);
    chk("bod off reset", hit, 0);
    chk("bod off irq", BROWNOUT_IRQ, 0);
    wr(rpmc_pkg::ADDR_CFG, 32'h05);
    cyc(8);
    chk("bod reset", CORE_RESET_N, 0);
    @(posedge CLK);
    BOD_LOW <= 1'b0;
    up();
    rd(rpmc_pkg::ADDR_CAUSE, 32'h04);
    wr(rpmc_pkg::ADDR_PWR, 32'h1);
    cyc(2);
    chk("idle cpu", CPU_RUN, 0);
    chk("idle periph", PERIPH_RUN, 1);
    @(posedge CLK);
    WAKE_IRQ <= 1'b1;
    @(posedge CLK);
    WAKE_IRQ <= 1'b0;
    cyc(2);
    chk("idle wake", CPU_RUN, 1);
    wr(rpmc_pkg::ADDR_CFG, 32'hc5);
    wr(rpmc_pkg::ADDR_PWR, 32'h2);
    cyc(2);
    chk("pd osc", OSC_RUN, 0);
    chk("pd bod", BOD_RUN, 1);
    chk("pd cmp", CMP_RUN, 1);
    chk("pd rtc", RTC_RUN, 1);
    chk("pd rc", RC_OSC_RUN, 1);
    @(posedge CLK);
    WAKE_IRQ <= 1'b1;
    @(posedge CLK);
    WAKE_IRQ <= 1'b0;
    cyc(2);
    chk("pd stays", OSC_RUN, 0);
    @(posedge CLK);
    PD_WAKE_IRQ <= 1'b1;
    @(posedge CLK);
    PD_WAKE_IRQ <= 1'b0;
    cyc(2);
    chk("pd wake", OSC_RUN, 1);
    wr(rpmc_pkg::ADDR_CFG, 32'h45);
    wr(rpmc_pkg::ADDR_PWR, 32'h3);
    cyc(2);
    chk("tpd bod", BOD_RUN, 0);
    chk("tpd cmp", CMP_RUN, 0);
    chk("tpd rc", RC_OSC_RUN, 0);
    wdt(2);
    watch(10, hit);
    chk("tpd reset wake", CPU_RUN, 1);
    chk("rtc after wdt", RTC_RESET_N, 1);
    rd(rpmc_pkg::ADDR_PWR, 32'h0);
    end_of_test();
  end
endmodule : rpmc_tb
